//--- hdl/init_err_pkg.sv
// constants, register layout and carrier types for the initiator error/status block
package init_err_pkg;
	localparam logic [15:0] STATUS_OFFSET      = 16'hd064;
	localparam logic [15:0] CONFIG_OFFSET      = 16'hd060;
	localparam logic [15:0] IRQ_STATUS_OFFSET  = 16'hd070;
	localparam logic [15:0] IRQ_MASK_OFFSET    = 16'hd074;
	localparam int          ADDR_W             = 16;
	localparam int          DATA_W             = 32;

	// configuration field positions
	localparam int CFG_STROBE_BIT   = 0;
	localparam int CFG_SWAP_BIT     = 1;
	localparam int CFG_BUSERR_BIT   = 3;
	localparam logic CFG_BUSERR_RESET = 1'b1;

	// status field positions
	localparam int ST_RETRY_BIT   = 0;
	localparam int ST_TRDY_BIT    = 1;
	localparam int ST_PARITY_BIT  = 5;
	localparam int ST_FATAL_BIT   = 6;
	localparam int ST_INB_BIT     = 7;
	localparam int ST_OUTB_BIT    = 8;

	// interrupt event bit positions
	localparam int IRQ_W          = 5;
	localparam int EV_RETRY       = 0;
	localparam int EV_TRDY        = 1;
	localparam int EV_PARITY      = 2;
	localparam int EV_FATAL       = 3;
	localparam int EV_SERR        = 4;

	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

	// outcome of one initiator cycle on the pci side
	typedef struct packed {
		logic done;
		logic is_read;
		logic master_abort;
		logic target_abort;
		logic parity_error;
		logic trdy_timeout;
		logic retry_timeout;
	} cycle_end_s;

	// answer to the internal bus for a finished read
	typedef struct packed {
		logic valid;
		logic bus_error;
		logic data_invalid;
	} read_answer_s;

	typedef enum logic [0:0] {
		SERR_IDLE  = 1'b0,
		SERR_PULSE = 1'b1
	} serr_state_e;

	typedef struct packed {
		logic                   read_fail_bus_error_enable;
		logic                   indirect_cycle_swap;
		logic                   direct_fatal_error_flag;
		logic                   direct_parity_error_flag;
		logic                   target_ready_timeout_flag;
		logic                   retry_timeout_flag;
		logic [IRQ_W-1:0]       irq_status;
		logic [IRQ_W-1:0]       irq_mask;
		serr_state_e            serr_state;
		read_answer_s           answer;
		logic [DATA_W-1:0]      rdata;
		logic                   swap_caught;
	} state_s;
endpackage : init_err_pkg

//--- hdl/init_err_status.sv
// initiator error, status and byte-swap control of the system-bus to pci bridge
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module init_err_status #(
	parameter int ADDR_W = init_err_pkg::ADDR_W,
	parameter int DATA_W = init_err_pkg::DATA_W
) (
	input  wire logic                      clk_sys,
	input  wire logic                      resetn,
	input  wire logic                      big_endian_mode,
	input  wire logic [ADDR_W-1:0]         reg_addr,
	input  wire logic [DATA_W-1:0]         reg_wdata,
	input  wire logic                      reg_write,
	input  wire logic                      reg_read,
	output logic      [DATA_W-1:0]         reg_rdata,
	input  wire init_err_pkg::cycle_end_s  cycle_end,
	input  wire logic                      outbound_fifo_count_zero,
	input  wire logic                      inbound_fifo_count_zero,
	output init_err_pkg::read_answer_s     read_answer,
	output logic                           indirect_cycle_swap,
	output logic                           serr_pulse,
	output logic                           irq
);
	init_err_pkg::state_s r_r;
	init_err_pkg::state_s r_nxt;

	logic             wr_cfg;
	logic             wr_status;
	logic             wr_irq_status;
	logic             wr_irq_mask;
	logic             fatal_event;
	logic             outbound_fifo_empty;
	logic             inbound_fifo_empty;
	logic             read_failed;
	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] config_word;
	logic [init_err_pkg::IRQ_W-1:0] events;

	assign wr_cfg        = reg_write && (reg_addr == init_err_pkg::CONFIG_OFFSET);
	assign wr_status     = reg_write && (reg_addr == init_err_pkg::STATUS_OFFSET);
	assign wr_irq_status = reg_write && (reg_addr == init_err_pkg::IRQ_STATUS_OFFSET);
	assign wr_irq_mask   = reg_write && (reg_addr == init_err_pkg::IRQ_MASK_OFFSET);

	assign outbound_fifo_empty = outbound_fifo_count_zero;
	assign inbound_fifo_empty  = inbound_fifo_count_zero;

	assign fatal_event = cycle_end.done && (cycle_end.master_abort || cycle_end.target_abort
		|| cycle_end.trdy_timeout || cycle_end.retry_timeout);
	assign read_failed = cycle_end.done && cycle_end.is_read && (fatal_event
		|| cycle_end.parity_error);

	assign events = {r_r.serr_state == init_err_pkg::SERR_IDLE && wr_cfg
			&& reg_wdata[init_err_pkg::CFG_STROBE_BIT],
		fatal_event,
		cycle_end.done && cycle_end.parity_error,
		cycle_end.done && cycle_end.trdy_timeout,
		cycle_end.done && cycle_end.retry_timeout};

	always_comb begin
		status_word = '0;
		status_word[init_err_pkg::ST_OUTB_BIT]   = outbound_fifo_empty;
		status_word[init_err_pkg::ST_INB_BIT]    = inbound_fifo_empty;
		status_word[init_err_pkg::ST_FATAL_BIT]  = r_r.direct_fatal_error_flag;
		status_word[init_err_pkg::ST_PARITY_BIT] = r_r.direct_parity_error_flag;
		status_word[init_err_pkg::ST_TRDY_BIT]   = r_r.target_ready_timeout_flag;
		status_word[init_err_pkg::ST_RETRY_BIT]  = r_r.retry_timeout_flag;
		config_word = '0;
		config_word[init_err_pkg::CFG_BUSERR_BIT] = r_r.read_fail_bus_error_enable;
		config_word[init_err_pkg::CFG_SWAP_BIT]   = r_r.indirect_cycle_swap;
	end

	always_comb begin
		r_nxt = r_r;
		if (wr_cfg) begin
			r_nxt.read_fail_bus_error_enable = reg_wdata[init_err_pkg::CFG_BUSERR_BIT];
			r_nxt.indirect_cycle_swap = reg_wdata[init_err_pkg::CFG_SWAP_BIT];
		end
		// one-clock serr pulse from a strobe write
		r_nxt.serr_state = init_err_pkg::SERR_IDLE;
		if (wr_cfg && reg_wdata[init_err_pkg::CFG_STROBE_BIT]) begin
			r_nxt.serr_state = init_err_pkg::SERR_PULSE;
		end
		// write-one clears first, then events set: set wins
		if (wr_status) begin
			if (reg_wdata[init_err_pkg::ST_FATAL_BIT]) begin
				r_nxt.direct_fatal_error_flag = 1'b0;
			end
			if (reg_wdata[init_err_pkg::ST_PARITY_BIT]) begin
				r_nxt.direct_parity_error_flag = 1'b0;
			end
			if (reg_wdata[init_err_pkg::ST_TRDY_BIT]) begin
				r_nxt.target_ready_timeout_flag = 1'b0;
			end
			if (reg_wdata[init_err_pkg::ST_RETRY_BIT]) begin
				r_nxt.retry_timeout_flag = 1'b0;
			end
		end
		if (fatal_event) begin
			r_nxt.direct_fatal_error_flag = 1'b1;
		end
		if (events[init_err_pkg::EV_PARITY]) begin
			r_nxt.direct_parity_error_flag = 1'b1;
		end
		if (events[init_err_pkg::EV_TRDY]) begin
			r_nxt.target_ready_timeout_flag = 1'b1;
		end
		if (events[init_err_pkg::EV_RETRY]) begin
			r_nxt.retry_timeout_flag = 1'b1;
		end
		// interrupt status, mask
		if (wr_irq_status) begin
			r_nxt.irq_status = r_r.irq_status & ~reg_wdata[init_err_pkg::IRQ_W-1:0];
		end
		r_nxt.irq_status = r_nxt.irq_status | events;
		if (wr_irq_mask) begin
			r_nxt.irq_mask = reg_wdata[init_err_pkg::IRQ_W-1:0];
		end
		// read answer to the internal bus
		r_nxt.answer = '0;
		if (cycle_end.done && cycle_end.is_read) begin
			r_nxt.answer.valid = 1'b1;
			r_nxt.answer.bus_error = read_failed && r_r.read_fail_bus_error_enable;
			r_nxt.answer.data_invalid = read_failed && !r_r.read_fail_bus_error_enable;
		end
		// register read data, one cycle after the strobe
		r_nxt.rdata = '0;
		if (reg_read) begin
			unique case (reg_addr)
				init_err_pkg::STATUS_OFFSET:     r_nxt.rdata = status_word;
				init_err_pkg::CONFIG_OFFSET:     r_nxt.rdata = config_word;
				init_err_pkg::IRQ_STATUS_OFFSET: r_nxt.rdata = DATA_W'(r_r.irq_status);
				init_err_pkg::IRQ_MASK_OFFSET:   r_nxt.rdata = DATA_W'(r_r.irq_mask);
				default:                         r_nxt.rdata = '0;
			endcase
		end
		// swap default caught on the first clock after reset release
		r_nxt.swap_caught = 1'b1;
		if (!r_r.swap_caught) begin
			r_nxt.indirect_cycle_swap = big_endian_mode;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			r_r.read_fail_bus_error_enable <= init_err_pkg::CFG_BUSERR_RESET;
			r_r.indirect_cycle_swap        <= 1'b0;
			r_r.direct_fatal_error_flag    <= init_err_pkg::FLAGS_RESET[3];
			r_r.direct_parity_error_flag   <= init_err_pkg::FLAGS_RESET[2];
			r_r.target_ready_timeout_flag  <= init_err_pkg::FLAGS_RESET[1];
			r_r.retry_timeout_flag         <= init_err_pkg::FLAGS_RESET[0];
			r_r.irq_status                 <= init_err_pkg::IRQ_RESET;
			r_r.irq_mask                   <= init_err_pkg::IRQ_RESET;
			r_r.serr_state                 <= init_err_pkg::SERR_IDLE;
			r_r.answer                     <= '0;
			r_r.rdata                      <= '0;
			r_r.swap_caught                <= 1'b0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign reg_rdata           = r_r.rdata;
	assign read_answer         = r_r.answer;
	assign indirect_cycle_swap = r_r.indirect_cycle_swap;
	assign serr_pulse          = (r_r.serr_state == init_err_pkg::SERR_PULSE);
	assign irq                 = |(r_r.irq_status & r_r.irq_mask);
endmodule : init_err_status

`default_nettype wire

//--- testbench/pci_far_end.sv
// far-side model: reports the end of each initiator cycle on the pci side
`timescale 1ns/1ps
`default_nettype none
module pci_far_end (
	input  wire logic                     go,
	input  wire logic                     is_read,
	input  wire logic [2:0]               kind,
	output var  init_err_pkg::cycle_end_s cycle_end
);
	// error lines keep showing the last kind while idle; only done qualifies them
	always_comb begin
		cycle_end = '0;
		cycle_end.done = go;
		cycle_end.is_read = is_read;
		cycle_end.master_abort = kind == 3'h1;
		cycle_end.target_abort = kind == 3'h2;
		cycle_end.parity_error = kind == 3'h3;
		cycle_end.trdy_timeout = kind == 3'h4;
		cycle_end.retry_timeout = kind == 3'h5;
	end
endmodule : pci_far_end
`default_nettype wire

//--- testbench/init_err_chk.sv
// assertions on the ports of the initiator error/status block
`timescale 1ns/1ps
`default_nettype none
module init_err_chk (
	input wire logic                       clk_sys,
	input wire logic                       resetn,
	input wire logic [15:0]                reg_addr,
	input wire logic [31:0]                reg_wdata,
	input wire logic                       reg_write,
	input wire logic                       reg_read,
	input wire logic [31:0]                reg_rdata,
	input wire init_err_pkg::cycle_end_s   cycle_end,
	input wire logic                       outbound_fifo_count_zero,
	input wire logic                       inbound_fifo_count_zero,
	input wire init_err_pkg::read_answer_s read_answer,
	input wire logic                       serr_pulse
);
	localparam logic [15:0] STS = init_err_pkg::STATUS_OFFSET;
	logic strobe_r;
	always_ff @(posedge clk_sys) strobe_r <= reg_write && reg_addr == init_err_pkg::CONFIG_OFFSET && reg_wdata[0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence st_rd; reg_read && reg_addr == STS; endsequence
	sequence rd_end; cycle_end.done && cycle_end.is_read; endsequence
	sequence fatal_end;
		cycle_end.done && (cycle_end.master_abort || cycle_end.target_abort
			|| cycle_end.trdy_timeout || cycle_end.retry_timeout);
	endsequence
	a_fatal_flag_set: assert property (fatal_end ##1 st_rd |=> reg_rdata[6]) else $error("fatal flag");
	a_serr_one_clock: assert property (serr_pulse == strobe_r) else $error("serr pulse");
	a_answer_on_read: assert property (rd_end |=> read_answer.valid) else $error("no answer");
	a_answer_reads_only: assert property (!cycle_end.done || !cycle_end.is_read |=> !read_answer.valid)
		else $error("stray answer");
	a_fail_one_way: assert property (rd_end ##0 fatal_end |=> read_answer.bus_error != read_answer.data_invalid)
		else $error("fail answer");
	a_rdata_idle_zero: assert property (!reg_read |=> reg_rdata == 32'h0) else $error("rdata idle");
	a_outbound_empty: assert property (st_rd |=> reg_rdata[8] == $past(outbound_fifo_count_zero))
		else $error("outbound flag");
	a_inbound_empty: assert property (st_rd |=> reg_rdata[7] == $past(inbound_fifo_count_zero))
		else $error("inbound flag");
	a_status_reserved: assert property (st_rd |=> reg_rdata[31:9] == 23'h0 && reg_rdata[4:2] == 3'h0)
		else $error("reserved bits");
endmodule : init_err_chk
bind init_err_status init_err_chk u_chk (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
	.reg_rdata, .cycle_end, .outbound_fifo_count_zero, .inbound_fifo_count_zero, .read_answer, .serr_pulse);
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the initiator error/status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [15:0] CFG = init_err_pkg::CONFIG_OFFSET;
	localparam logic [15:0] STS = init_err_pkg::STATUS_OFFSET;
	logic clk_sys, resetn, big_endian_mode, reg_write, reg_read, go, is_read, ob_e, ib_e, swap, serr, irq;
	logic [15:0]               reg_addr;
	logic [31:0]               reg_wdata, reg_rdata, v;
	int                        seed;
	logic [2:0]                kind;
	logic [1:0]                lv;
	int                        bad_count, cmp_count, cyc;
	init_err_pkg::cycle_end_s   cyc_end;
	init_err_pkg::read_answer_s ans;
	pci_far_end far (.go, .is_read, .kind, .cycle_end(cyc_end));
	init_err_status dut (.clk_sys, .resetn, .big_endian_mode, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .cycle_end(cyc_end), .outbound_fifo_count_zero(ob_e), .inbound_fifo_count_zero(ib_e),
		.read_answer(ans), .indirect_cycle_swap(swap), .serr_pulse(serr), .irq);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task results;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask : wr
	task rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	// e is the expected {valid, bus_error, data_invalid}
	task ev(input logic r, input logic [2:0] k, input logic [2:0] e);
		@(posedge clk_sys);
		go <= 1'b1;
		is_read <= r;
		kind <= k;
		@(posedge clk_sys);
		go <= 1'b0;
		#1 chk({29'h0, ans}, {29'h0, e});
	endtask : ev
	function automatic logic [31:0] st_bits(input logic [2:0] k);
		logic [31:0] f;
		f = 32'h180;
		if (k inside {3'h1, 3'h2, 3'h4, 3'h5}) f[init_err_pkg::ST_FATAL_BIT] = 1'b1;
		if (k == 3'h3) f[init_err_pkg::ST_PARITY_BIT] = 1'b1;
		if (k == 3'h4) f[init_err_pkg::ST_TRDY_BIT] = 1'b1;
		if (k == 3'h5) f[init_err_pkg::ST_RETRY_BIT] = 1'b1;
		return f;
	endfunction : st_bits
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			results();
		end
	end
	initial begin
		{resetn, big_endian_mode, reg_write, reg_read, go, is_read, kind} = '0;
		{reg_addr, reg_wdata, cyc, bad_count, cmp_count} = '0;
		{ob_e, ib_e} = 2'h3;
		seed = 32'h4258;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(CFG, 32'h8);
		rd(STS, 32'h180);
		for (int k = 1; k < 6; k++) begin
			ev(1'b1, k[2:0], 3'h6);
			rd(STS, st_bits(k[2:0]));
			v = $random(seed);
			wr(STS, v & 32'hffffff9c);
			rd(STS, st_bits(k[2:0]));
			wr(STS, 32'h63);
			rd(STS, 32'h180);
		end
		wr(CFG, 32'h0);
		ev(1'b1, 3'h2, 3'h5);
		ev(1'b1, 3'h0, 3'h4);
		ev(1'b0, 3'h4, 3'h0);
		rd(STS, st_bits(3'h4));
		wr(CFG, 32'h3);
		#1 chk({30'h0, serr, swap}, 32'h3);
		@(posedge clk_sys);
		#1 chk({31'h0, serr}, 32'h0);
		rd(CFG, 32'h2);
		wr(CFG, 32'h4);
		rd(CFG, 32'h0);
		rd(16'hd0fc, 32'h0);
		wr(init_err_pkg::IRQ_STATUS_OFFSET, 32'h1f);
		ev(1'b0, 3'h1, 3'h0);
		chk({31'h0, irq}, 32'h0);
		wr(init_err_pkg::IRQ_MASK_OFFSET, 32'h8);
		#1 chk({31'h0, irq}, 32'h1);
		wr(init_err_pkg::IRQ_STATUS_OFFSET, 32'h8);
		#1 chk({31'h0, irq}, 32'h0);
		wr(STS, 32'h63);
		repeat (8) begin
			lv = $random(seed);
			@(posedge clk_sys);
			{ob_e, ib_e} <= lv;
			rd(STS, {23'h0, lv, 7'h0});
		end
		// second reset in mid-run, strapped big-endian this time
		@(posedge clk_sys);
		{ob_e, ib_e} <= 2'h3;
		resetn <= 1'b0;
		big_endian_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(CFG, 32'ha);
		rd(STS, 32'h180);
		results();
	end
endmodule : tb_top
`default_nettype wire
